/* shared/adl_pkg.sv */
// Purpose: Shared constants and carriers for one division of the
//          automatic depressurization logic.
// Assumes: 50 MHz ref_clk; all counts derive from the times below.
// Notes:   Long timers run on a 1 ms tick so the counters stay small.
//
// How it works
// - Each parameter counts only while two of four channels agree, live.
// - Each confirmed parameter latches on its own and annunciates.
// - Drywell pressure latch clears only by manual reset, never itself.
// - Manual resets are ignored while both votes are still satisfied.
// - Resetting initiation latches leaves timers running if conditions hold.
// - Level clearing before expiry resets timers; each new dip restarts.
// - Timing annunciation is high whenever any timer is counting.
// - Fire after pressure plus 29 s low level, else 8 min then 29 s.
// - Pump permissive is OR of three low and two high pressure pumps.
// - On expiry this division energizes its own pilot on every valve.
// - Indicator is high whenever any pilot output is energized.
// - Auto start needs low level with power-monitor permissive; inhibit blocks.
// - Manual inhibit acts only before firing; cannot close opened valves.
// - Inhibit annunciation is high for as long as inhibit is active.
// - Both collars rotated raise armed annunciation before buttons count.
// - Armed plus both buttons fires at once, bypassing timers, if pumps run.
// - Two delay circuits per division; firing needs both to expire.
// - Per valve selector; open position opens that valve regardless of logic.
// - Paired level channels are cross compared and disagreement flagged.
// - Channel verification result is refreshed every ten minutes.
// - Verification never gates or delays actuation.

package adl_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int ADL_CLK_NS = 20;
  localparam int ADL_TICK_NS = 1000000;
  localparam int ADL_TICK_CYCLES = ADL_TICK_NS / ADL_CLK_NS;
  localparam int ADL_ACT_S = 29;
  localparam int ADL_BYP_MIN = 8;
  localparam int ADL_VERIFY_MIN = 10;
  localparam int ADL_ACT_MS = ADL_ACT_S * 1000;
  localparam int ADL_BYP_MS = ADL_BYP_MIN * 60 * 1000;
  localparam int ADL_VERIFY_MS = ADL_VERIFY_MIN * 60 * 1000;
  localparam int ADL_MS_W = 20;
  localparam int ADL_TICK_W = 16;
  localparam int ADL_FILT_CYCLES = 4;
  localparam int ADL_FILT_W = 3;

  // ********************************************************************
  // Structure sizes and encodings
  // ********************************************************************
  localparam int ADL_VALVES = 8;
  localparam int ADL_IN_W = 40;
  localparam logic [1:0] ADL_SEL_OFF = 2'h0;
  localparam logic [1:0] ADL_SEL_AUTO = 2'h1;
  localparam logic [1:0] ADL_SEL_OPEN = 2'h2;

  typedef struct packed {
    logic [3:0] dw_trip;
    logic [3:0] lvl_trip;
    logic [3:0] lvl_aux;
    logic [4:0] pump_press;
    logic transient_without_scram_perm;
  } adl_sense_s;

  typedef struct packed {
    logic inhibit;
    logic man_reset;
    logic [1:0] collar;
    logic [1:0] button;
  } adl_oper_s;

  typedef logic [ADL_VALVES-1:0][1:0] adl_sel_t;

  typedef struct packed {
    logic dw_latched;
    logic lvl_latched;
    logic init_latched;
    logic timing;
    logic inhibit;
    logic armed;
    logic pilot_on;
    logic mismatch;
    logic [3:0] chan_fault;
  } adl_annun_s;

  typedef enum {ADL_ST_STANDBY, ADL_ST_FIRED} adl_state_e;

endpackage : adl_pkg

/* rtl/adl_filter.sv */
// Purpose: Synchronize and deglitch a vector of asynchronous inputs.
// Assumes: Inputs are slow switch or trip levels.
// Notes:   A bit changes only after ADL_FILT_CYCLES stable samples.
`timescale 1ns/1ns
module adl_filter #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  import adl_pkg::*;

  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [W-1:0] next_clean;
  logic [W-1:0][ADL_FILT_W-1:0] cnt;
  logic [W-1:0][ADL_FILT_W-1:0] next_cnt;

  // *******************************************************************
  // Stability counters, one per bit
  // *******************************************************************
  // A one-cycle glitch never reaches the voting logic
  always_comb begin
    next_clean = clean;
    next_cnt = cnt;
    for (int i = 0; i < W; i++) begin
      if (sync2[i] == clean[i]) begin
        next_cnt[i] = '0;
      end else if (cnt[i] == ADL_FILT_W'(ADL_FILT_CYCLES - 1)) begin
        next_cnt[i] = '0;
        next_clean[i] = sync2[i];
      end else begin
        next_cnt[i] = cnt[i] + 1'b1;
      end
    end
  end

  // Two-flop synchronizer then registered filter state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      clean <= '0;
      cnt <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      clean <= next_clean;
      cnt <= next_cnt;
    end
  end

endmodule : adl_filter

/* rtl/adl_top.sv */
// Purpose: One division of automatic depressurization voting and timing.
// Assumes: Trip and switch inputs are asynchronous levels, high = active.
// Notes:   Long delays are parameters so simulation can shorten them.
`timescale 1ns/1ns
module adl_top #(
  parameter int TICK_CYCLES = adl_pkg::ADL_TICK_CYCLES,
  parameter int ACT_MS = adl_pkg::ADL_ACT_MS,
  parameter int BYP_MS = adl_pkg::ADL_BYP_MS,
  parameter int VERIFY_MS = adl_pkg::ADL_VERIFY_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire adl_pkg::adl_sense_s sense,
  input wire adl_pkg::adl_oper_s oper,
  input wire adl_pkg::adl_sel_t valve_sel,
  output adl_pkg::adl_annun_s annun,
  output logic [adl_pkg::ADL_VALVES-1:0] pilot
);
  import adl_pkg::*;

  localparam logic [ADL_TICK_W-1:0] TICK_LIM = ADL_TICK_W'(TICK_CYCLES - 1);
  localparam logic [ADL_MS_W-1:0] ACT_LIM = ADL_MS_W'(ACT_MS);
  localparam logic [ADL_MS_W-1:0] BYP_LIM = ADL_MS_W'(BYP_MS);
  localparam logic [ADL_MS_W-1:0] VER_LIM = ADL_MS_W'(VERIFY_MS - 1);

  // *******************************************************************
  // Helper functions
  // *******************************************************************
  // Two or more of four channels tripped
  function automatic logic vote_2of4(input logic [3:0] ch);
    logic [2:0] n;
    n = 3'(ch[0]) + 3'(ch[1]) + 3'(ch[2]) + 3'(ch[3]);
    return n >= 3'h2;
  endfunction : vote_2of4

  // Saturating ms timer: clears whenever its run condition drops
  function automatic logic [ADL_MS_W-1:0] tmr_next(
    input logic run,
    input logic tick,
    input logic [ADL_MS_W-1:0] cnt,
    input logic [ADL_MS_W-1:0] lim
  );
    logic [ADL_MS_W-1:0] r;
    r = cnt;
    if (!run) begin
      r = '0;
    end else if (tick && cnt != lim) begin
      r = cnt + 1'b1;
    end
    return r;
  endfunction : tmr_next

  // *******************************************************************
  // Input conditioning
  // *******************************************************************
  adl_sense_s s;
  adl_oper_s o;
  adl_sel_t sel;

  adl_filter #(
    .W(ADL_IN_W)
  ) u_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw({sense, oper, valve_sel}),
    .clean({s, o, sel})
  );

  // *******************************************************************
  // Combinational decisions
  // *******************************************************************
  logic dw_vote;
  logic lvl_vote;
  logic pump_perm;
  logic reset_ok;
  logic byp_done;
  logic act_run;
  logic act_done;
  logic auto_fire;
  logic man_fire;
  logic [3:0] mism_now;
  // Timer counts are read by the decisions below, so declared first
  logic [ADL_MS_W-1:0] byp_cnt;
  logic [ADL_MS_W-1:0] next_byp_cnt;
  logic [ADL_MS_W-1:0] act_a_cnt;
  logic [ADL_MS_W-1:0] next_act_a_cnt;
  logic [ADL_MS_W-1:0] act_b_cnt;
  logic [ADL_MS_W-1:0] next_act_b_cnt;

  // Live votes drive timing, latches only drive annunciation
  assign dw_vote = vote_2of4(s.dw_trip);
  assign lvl_vote = vote_2of4(s.lvl_trip);
  assign pump_perm = |s.pump_press;
  // Reset refused while both parameters still vote
  assign reset_ok = o.man_reset && !(dw_vote && lvl_vote);
  assign byp_done = byp_cnt == BYP_LIM;
  // Timers restart from zero whenever level recovers
  assign act_run = lvl_vote && s.transient_without_scram_perm && (dw_vote || byp_done);
  assign act_done = (act_a_cnt == ACT_LIM) && (act_b_cnt == ACT_LIM);
  // Inhibit only stops a start; verification is absent from this path
  assign auto_fire = act_run && act_done && pump_perm && !o.inhibit;
  // Buttons are taken only once armed has been registered
  assign man_fire = annun.armed && (&o.button) && pump_perm;
  assign mism_now = s.lvl_trip ^ s.lvl_aux;

  // *******************************************************************
  // State
  // *******************************************************************
  adl_state_e state;
  adl_state_e next_state;
  logic [ADL_TICK_W-1:0] tick_cnt;
  logic [ADL_TICK_W-1:0] next_tick_cnt;
  logic tick;
  logic next_tick;
  logic [ADL_MS_W-1:0] ver_cnt;
  logic [ADL_MS_W-1:0] next_ver_cnt;
  logic [3:0] mism_acc;
  logic [3:0] next_mism_acc;
  adl_annun_s next_annun;
  logic [ADL_VALVES-1:0] next_pilot;

  // Millisecond tick divider keeps the long counters narrow
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 1'b1;
    if (tick_cnt == TICK_LIM) begin
      next_tick_cnt = '0;
      next_tick = 1'b1;
    end
  end

  // Timers: bypass runs on low level alone, delay pair on full start
  always_comb begin
    next_byp_cnt = tmr_next(lvl_vote, tick, byp_cnt, BYP_LIM);
    next_act_a_cnt = tmr_next(act_run, tick, act_a_cnt, ACT_LIM);
    next_act_b_cnt = tmr_next(act_run, tick, act_b_cnt, ACT_LIM);
  end

  // Firing sequence; once fired, inhibit has no say
  always_comb begin
    next_state = state;
    case (state)
      ADL_ST_STANDBY: begin
        if (auto_fire || man_fire) begin
          next_state = ADL_ST_FIRED;
        end
      end
      ADL_ST_FIRED: begin
        if (reset_ok && !lvl_vote) begin
          next_state = ADL_ST_STANDBY;
        end
      end
      default: begin
        next_state = ADL_ST_STANDBY;
      end
    endcase
  end

  // Periodic channel verification, sticky between strobes
  always_comb begin
    next_ver_cnt = ver_cnt;
    next_mism_acc = mism_acc | mism_now;
    next_annun = annun;
    if (tick) begin
      next_ver_cnt = ver_cnt + 1'b1;
      if (ver_cnt == VER_LIM) begin
        next_ver_cnt = '0;
        next_annun.chan_fault = mism_acc | mism_now;
        next_mism_acc = mism_now;
      end
    end
    next_annun.mismatch = |mism_now;
    // Latches: set wins over a same-cycle reset
    next_annun.dw_latched = dw_vote || (annun.dw_latched && !reset_ok);
    next_annun.lvl_latched = lvl_vote || (annun.lvl_latched && !reset_ok);
    // Latch reset touches nothing in the timers
    next_annun.init_latched = act_run ||
      (annun.init_latched && !reset_ok);
    next_annun.timing = (lvl_vote && !byp_done) ||
      (act_run && !act_done);
    next_annun.inhibit = o.inhibit;
    next_annun.armed = &o.collar;
    next_annun.pilot_on = |next_pilot;
  end

  // Pilots: division drive on every valve, selector open overrides
  always_comb begin
    for (int v = 0; v < ADL_VALVES; v++) begin
      next_pilot[v] = (next_state == ADL_ST_FIRED) ||
        (sel[v] == ADL_SEL_OPEN);
    end
  end

  // Registers only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ADL_ST_STANDBY;
      tick_cnt <= '0;
      tick <= 1'b0;
      byp_cnt <= '0;
      act_a_cnt <= '0;
      act_b_cnt <= '0;
      ver_cnt <= '0;
      mism_acc <= '0;
      annun <= '0;
      pilot <= '0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      byp_cnt <= next_byp_cnt;
      act_a_cnt <= next_act_a_cnt;
      act_b_cnt <= next_act_b_cnt;
      ver_cnt <= next_ver_cnt;
      mism_acc <= next_mism_acc;
      annun <= next_annun;
      pilot <= next_pilot;
    end
  end

endmodule : adl_top

/* test/adl_checker.sv */
// Purpose: Port assertions for one depressurization division.
// Assumes: Inputs reach outputs about 7 cycles after the pins.
// Notes:   Eight steady samples plus two edges cover that latency.
`timescale 1ns/1ns
module adl_checker
  import adl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire adl_pkg::adl_sense_s sense,
  input wire adl_pkg::adl_oper_s oper,
  input wire adl_pkg::adl_sel_t valve_sel,
  input wire adl_pkg::adl_annun_s annun,
  input wire logic [adl_pkg::ADL_VALVES-1:0] pilot
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Level steady long enough to pass the filter
  sequence s_held(x);
    (x)[*8];
  endsequence
  a_reset_zero: assert property (disable iff (1'b0)
    rst |=> annun == '0 && pilot == '0) else $error("reset not clean");
  a_pilot_lamp: assert property (|pilot |-> annun.pilot_on)
    else $error("pilot lamp dark");
  a_inhibit_on: assert property (
    s_held(oper.inhibit) |=> ##1 annun.inhibit) else $error("no inhibit");
  a_inhibit_off: assert property (
    s_held(!oper.inhibit) |=> ##1 !annun.inhibit) else $error("stuck inh");
  a_armed_lamp: assert property (
    s_held(oper.collar == 2'h3) |=> ##1 annun.armed) else $error("unarmed");
  a_open_valve: assert property (
    s_held(valve_sel[0] == ADL_SEL_OPEN) |=> ##1 pilot[0])
    else $error("open ignored");
  a_level_gone: assert property (
    s_held($countones(sense.lvl_trip) < 2) |=> ##1 !annun.timing)
    else $error("timer left running");
  a_dw_hold: assert property (
    s_held(!oper.man_reset) ##0 annun.dw_latched |=> annun.dw_latched)
    else $error("pressure latch lost");
  a_chan_cmp: assert property (
    s_held(sense.lvl_trip != sense.lvl_aux) |=> ##1 annun.mismatch)
    else $error("no mismatch");
endmodule : adl_checker

/* test/adl_field.sv */
// Purpose: Sensor side model turning channel counts into trips.
// Assumes: Counts 0 to 4; bench changes them at the falling edge.
// Notes:   Trips fill from channel 0 upward.
`timescale 1ns/1ns
module adl_field
  import adl_pkg::*;
(
  input wire logic [2:0] dw_n,
  input wire logic [2:0] lvl_n,
  input wire logic [3:0] aux_flip,
  input wire logic [4:0] pumps,
  input wire logic perm,
  output adl_pkg::adl_sense_s sense
);
  logic [4:0] dw_v;
  logic [4:0] lv_v;
  // Five bits so that four channels do not wrap
  assign dw_v = (5'h01 << dw_n) - 5'h01;
  assign lv_v = (5'h01 << lvl_n) - 5'h01;
  // Second level set follows the first unless told to disagree
  always_comb begin
    sense.dw_trip = dw_v[3:0];
    sense.lvl_trip = lv_v[3:0];
    sense.lvl_aux = lv_v[3:0] ^ aux_flip;
    sense.pump_press = pumps;
    sense.transient_without_scram_perm = perm;
  end
endmodule : adl_field

/* test/adl_top_bench.sv */
// Purpose: Scenario bench for one depressurization division.
// Assumes: Tick 4 cycles, delay 5, bypass 10, verify 20 ticks.
// Notes:   Waits carry margin for the 7 cycle input latency.
`timescale 1ns/1ns
module adl_top_bench;
  import adl_pkg::*;
  logic ref_clk;
  logic rst;
  logic [2:0] dw_n;
  logic [2:0] lvl_n;
  logic [3:0] aux_flip;
  logic [4:0] pumps;
  logic perm;
  adl_sense_s sense;
  adl_oper_s oper;
  adl_sel_t valve_sel;
  adl_annun_s annun;
  logic [ADL_VALVES-1:0] pilot;
  int n_fail;
  int checks;
  int cyc;
  adl_field u_adl_field (.dw_n(dw_n), .lvl_n(lvl_n), .aux_flip(aux_flip),
    .pumps(pumps), .perm(perm), .sense(sense));
  adl_top #(.TICK_CYCLES(4), .ACT_MS(5), .BYP_MS(10), .VERIFY_MS(20))
    u_adl_top (.ref_clk(ref_clk), .rst(rst), .sense(sense), .oper(oper),
    .valve_sel(valve_sel), .annun(annun), .pilot(pilot));
  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Cut a hang short; the whole run needs about 1070 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(int n);
    repeat (n) @(negedge ref_clk);
  endtask : step
  task automatic set_in(logic [2:0] d, logic [2:0] l, logic [4:0] p);
    dw_n = d;
    lvl_n = l;
    pumps = p;
  endtask : set_in
  task automatic do_reset;
    rst = 1'b1;
    set_in(3'h0, 3'h0, 5'h00);
    perm = 1'b1;
    aux_flip = 4'h0;
    oper = '0;
    valve_sel = {ADL_VALVES{ADL_SEL_AUTO}};
    step(2);
    rst = 1'b0;
  endtask : do_reset
  task automatic pulse_reset;
    oper.man_reset = 1'b1;
    step(10);
    oper.man_reset = 1'b0;
    step(10);
  endtask : pulse_reset
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_votes;
    do_reset();
    set_in(3'h2, 3'h2, 5'h01);
    step(2);
    set_in(3'h1, 3'h1, 5'h01);
    step(60);
    chk("latches", 12'h0, annun[11:8]);
    chk("one of four", 12'h0, pilot);
    $display("test votes done");
  endtask : t_votes
  task automatic t_dw_path;
    do_reset();
    set_in(3'h2, 3'h2, 5'h01);
    step(20);
    chk("early pilot", 12'h0, pilot);
    chk("timing", 12'h1, annun.timing);
    step(25);
    chk("pilot", 12'hff, pilot);
    chk("latches", 12'h7, annun[11:9]);
    oper.inhibit = 1'b1;
    step(12);
    chk("late inhibit", 12'hff, pilot);
    chk("inhibit lamp", 12'h1, annun.inhibit);
    pulse_reset();
    chk("reset refused", 12'hff, pilot);
    set_in(3'h0, 3'h1, 5'h01);
    step(12);
    chk("dw held", 12'h1, annun.dw_latched);
    pulse_reset();
    chk("dw cleared", 12'h0, annun.dw_latched);
    chk("pilot cleared", 12'h0, pilot);
    $display("test pressure path done");
  endtask : t_dw_path
  task automatic t_level_path;
    do_reset();
    set_in(3'h0, 3'h3, 5'h10);
    step(20);
    pulse_reset();
    chk("timing kept", 12'h1, annun.timing);
    step(5);
    chk("bypass pilot", 12'h0, pilot);
    step(45);
    chk("level pilot", 12'hff, pilot);
    $display("test level path done");
  endtask : t_level_path
  task automatic t_abort;
    do_reset();
    set_in(3'h0, 3'h4, 5'h04);
    step(30);
    set_in(3'h0, 3'h1, 5'h04);
    step(12);
    chk("aborted", 12'h0, annun.timing);
    set_in(3'h0, 3'h2, 5'h04);
    step(63);
    chk("fresh start", 12'h0, pilot);
    step(32);
    chk("refired", 12'hff, pilot);
    $display("test abort done");
  endtask : t_abort
  task automatic t_blocks;
    for (int i = 0; i < 5; i++) begin
      do_reset();
      set_in(3'h2, 3'h2, 5'h01 << i);
      step(45);
      chk("one pump", 12'hff, pilot);
    end
    for (int i = 0; i < 3; i++) begin
      do_reset();
      set_in(3'h2, 3'h2, (i == 0) ? 5'h00 : 5'h1f);
      perm = (i != 1);
      oper.inhibit = (i == 2);
      step(60);
      chk("blocked", 12'h0, pilot);
    end
    $display("test blocks done");
  endtask : t_blocks
  task automatic t_manual;
    do_reset();
    pumps = 5'h02;
    oper.button = 2'h3;
    step(12);
    chk("unarmed", 12'h0, pilot);
    oper.button = 2'h0;
    oper.collar = 2'h3;
    step(12);
    chk("armed", 12'h1, annun.armed);
    oper.button = 2'h3;
    step(12);
    chk("manual fire", 12'hff, pilot);
    do_reset();
    oper.collar = 2'h3;
    oper.button = 2'h3;
    step(30);
    chk("no pump", 12'h0, pilot);
    valve_sel[5] = ADL_SEL_OPEN;
    valve_sel[0] = ADL_SEL_OFF;
    step(12);
    chk("selector", 12'h20, pilot);
    $display("test manual done");
  endtask : t_manual
  task automatic t_compare;
    do_reset();
    aux_flip = 4'h1;
    step(12);
    chk("mismatch", 12'h1, annun.mismatch);
    step(100);
    chk("fault", 12'h1, annun.chan_fault);
    set_in(3'h2, 3'h2, 5'h08);
    step(45);
    chk("fire in test", 12'hff, pilot);
    $display("test compare done");
  endtask : t_compare
  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  initial begin
    t_votes();
    t_dw_path();
    t_level_path();
    t_abort();
    t_blocks();
    t_manual();
    t_compare();
    close_out();
  end
endmodule : adl_top_bench
bind adl_top adl_checker u_adl_checker (.ref_clk(ref_clk), .rst(rst),
  .sense(sense), .oper(oper), .valve_sel(valve_sel), .annun(annun),
  .pilot(pilot));
